// File: rtl/pwm_unit_regs.vh
// register map, field positions and reset values of the timer pwm unit
// assumes a 32-bit axi4-lite slave with word-aligned byte addresses
`ifndef PWM_UNIT_REGS_VH
`define PWM_UNIT_REGS_VH

`define CLKSEL_OFFSET   12'h290
`define DUTY_HI_OFFSET  12'h000
`define DUTY_LO_OFFSET  12'h004
`define PERIOD_OFFSET   12'h008
`define PRESCALE_OFFSET 12'h00c
`define CONTROL_OFFSET  12'h010
`define STATUS_OFFSET   12'h014

`define CLKSEL_MSB      3
`define DUTY_LO_MSB     7
`define DUTY_LO_LSB     6
`define PRESCALE_MSB    1
`define POSTSCALE_MSB   5
`define POSTSCALE_LSB   2

`define PERIOD_RESET    8'hff
`define PRESCALE_1TO1   2'h0
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// File: rtl/timer_based_pwm_unit.v
// timer driven 10-bit pwm with axi4-lite register access
// assumes ext_clk_in pins are asynchronous to aclk; one clock domain
// Function
// RULE1 - period start clears timer, output goes active
// RULE2 - zero duty keeps output inactive whole period
// RULE3 - duty registers buffered at each period start
// RULE4 - duty writes anytime, running period undisturbed
// RULE5 - duty is high byte plus low bits 7:6
// RULE6 - time base is timer plus two low bits
// RULE7 - prescale 1:1 counts low bits on system clock; code counts them on each tick of the selected source
// RULE8 - pulse width equals duty times tick period
// RULE9 - postscaler never affects output or period
// RULE10 - resolution depends on period value
// RULE11 - width beyond period leaves pin unchanged
// RULE12 - four-bit field selects timer clock source
// RULE13 - output inactive once time base reaches duty
// RULE14 - new period when timer equals period value
`include "pwm_unit_regs.vh"

module timer_based_pwm_unit #(
    parameter EXT_CLKS = 4
) (
    // clock and reset
    input  wire                aclk,
    input  wire                aresetn,
    // axi4-lite write
    input  wire [11:0]         s_axi_awaddr,
    input  wire                s_axi_awvalid,
    output wire                s_axi_awready,
    input  wire [31:0]         s_axi_wdata,
    input  wire [3:0]          s_axi_wstrb,
    input  wire                s_axi_wvalid,
    output wire                s_axi_wready,
    output reg  [1:0]          s_axi_bresp,
    output reg                 s_axi_bvalid,
    input  wire                s_axi_bready,
    // axi4-lite read
    input  wire [11:0]         s_axi_araddr,
    input  wire                s_axi_arvalid,
    output wire                s_axi_arready,
    output reg  [31:0]         s_axi_rdata,
    output reg  [1:0]          s_axi_rresp,
    output reg                 s_axi_rvalid,
    input  wire                s_axi_rready,
    // timer clock inputs and pwm pin
    input  wire [EXT_CLKS-1:0] ext_clk_in,
    output reg                 pwm_out
);

    ////////////////////////////////////////////////////////////////////////
    // registers

    reg  [3:0]          clksel_q;
    reg  [7:0]          duty_hi_q;
    reg  [7:0]          duty_lo_q;
    reg  [7:0]          period_q;
    reg  [7:0]          prescale_q;
    reg                 enable_q;
    reg  [11:0]         awaddr_q;
    reg  [31:0]         wdata_q;
    reg  [3:0]          wstrb_q;
    reg                 aw_full_q;
    reg                 w_full_q;
    reg  [EXT_CLKS-1:0] sync1_q;
    reg  [EXT_CLKS-1:0] sync2_q;
    reg  [EXT_CLKS-1:0] sync3_q;
    reg  [EXT_CLKS-1:0] stable_q;
    reg  [EXT_CLKS-1:0] stable_prev_q;
    reg  [7:0]          tmr_q;
    reg  [1:0]          low_q;
    reg  [7:0]          pre_cnt_q;
    reg  [9:0]          duty_buf_q;
    reg                 width_bad_q;
    reg                 period_start_q;

    assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_full_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    function [7:0] merge_byte;
        input [7:0] old_val;
        input [7:0] new_val;
        input       lane_en;
        begin
            merge_byte = lane_en ? new_val : old_val;
        end
    endfunction

    function known_addr;
        input [11:0] a;
        begin
            if (a == `CLKSEL_OFFSET) begin
                known_addr = 1'b1;
            end else if (a == `DUTY_HI_OFFSET || a == `DUTY_LO_OFFSET) begin
                known_addr = 1'b1;
            end else if (a == `PERIOD_OFFSET || a == `PRESCALE_OFFSET) begin
                known_addr = 1'b1;
            end else if (a == `CONTROL_OFFSET || a == `STATUS_OFFSET) begin
                known_addr = 1'b1;
            end else begin
                known_addr = 1'b0;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // write channel: address and data taken in either order

    wire       aw_have = aw_full_q || (s_axi_awvalid && s_axi_awready);
    wire       w_have  = w_full_q || (s_axi_wvalid && s_axi_wready);
    wire [11:0] wa     = aw_full_q ? awaddr_q : s_axi_awaddr;
    wire [31:0] wd     = w_full_q ? wdata_q : s_axi_wdata;
    wire [3:0]  ws     = w_full_q ? wstrb_q : s_axi_wstrb;
    wire        do_wr  = aw_have && w_have && !s_axi_bvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q    <= 1'b0;
            w_full_q     <= 1'b0;
            awaddr_q     <= 12'h000;
            wdata_q      <= 32'h00000000;
            wstrb_q      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
            clksel_q     <= 4'h0;
            duty_hi_q    <= 8'h00;
            duty_lo_q    <= 8'h00;
            period_q     <= `PERIOD_RESET;
            prescale_q   <= 8'h00;
            enable_q     <= 1'b0;
        end else begin
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (do_wr) begin
                aw_full_q    <= 1'b0;
                w_full_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= known_addr(wa) ? `RESP_OKAY : `RESP_SLVERR;
                // duty writes land in the shadow only [RULE4]
                if (wa == `CLKSEL_OFFSET) begin
                    if (ws[0]) clksel_q <= wd[`CLKSEL_MSB:0]; // [RULE12]
                end else if (wa == `DUTY_HI_OFFSET) begin
                    duty_hi_q <= merge_byte(duty_hi_q, wd[7:0], ws[0]);
                end else if (wa == `DUTY_LO_OFFSET) begin
                    duty_lo_q <= merge_byte(duty_lo_q, wd[7:0], ws[0]);
                end else if (wa == `PERIOD_OFFSET) begin
                    period_q <= merge_byte(period_q, wd[7:0], ws[0]);
                end else if (wa == `PRESCALE_OFFSET) begin
                    // postscale bits stored for software only [RULE9]
                    prescale_q <= merge_byte(prescale_q, wd[7:0], ws[0]);
                end else if (wa == `CONTROL_OFFSET) begin
                    if (ws[0]) enable_q <= wd[0];
                end
            end else begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_full_q <= 1'b1;
                    awaddr_q  <= s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_full_q <= 1'b1;
                    wdata_q  <= s_axi_wdata;
                    wstrb_q  <= s_axi_wstrb;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read channel

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `RESP_OKAY;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) s_axi_rvalid <= 1'b0;
        end else if (s_axi_arvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `RESP_OKAY;
            if (s_axi_araddr == `CLKSEL_OFFSET) begin
                s_axi_rdata <= {28'h0000000, clksel_q};
            end else if (s_axi_araddr == `DUTY_HI_OFFSET) begin
                s_axi_rdata <= {24'h000000, duty_hi_q};
            end else if (s_axi_araddr == `DUTY_LO_OFFSET) begin
                s_axi_rdata <= {24'h000000, duty_lo_q};
            end else if (s_axi_araddr == `PERIOD_OFFSET) begin
                s_axi_rdata <= {24'h000000, period_q};
            end else if (s_axi_araddr == `PRESCALE_OFFSET) begin
                s_axi_rdata <= {24'h000000, prescale_q};
            end else if (s_axi_araddr == `CONTROL_OFFSET) begin
                s_axi_rdata <= {31'h00000000, enable_q};
            end else if (s_axi_araddr == `STATUS_OFFSET) begin
                s_axi_rdata <= {12'h000, width_bad_q, pwm_out, duty_buf_q, tmr_q};
            end else begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= `RESP_SLVERR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clock source selection; code 0 is the system clock

    always @(posedge aclk) begin
        if (!aresetn) begin
            sync1_q       <= {EXT_CLKS{1'b0}};
            sync2_q       <= {EXT_CLKS{1'b0}};
            sync3_q       <= {EXT_CLKS{1'b0}};
            stable_q      <= {EXT_CLKS{1'b0}};
            stable_prev_q <= {EXT_CLKS{1'b0}};
        end else begin
            sync1_q       <= ext_clk_in;
            sync2_q       <= sync1_q;
            sync3_q       <= sync2_q;
            // a level counts once stages two and three agree
            stable_q      <= (sync2_q & sync3_q) | (stable_q & (sync2_q | sync3_q));
            stable_prev_q <= stable_q;
        end
    end

    wire [EXT_CLKS-1:0] ext_rise = stable_q & ~stable_prev_q;
    wire [3:0]          ext_idx  = clksel_q - 4'h1;
    // codes past the last input stop the timer
    wire src_tick = (clksel_q == 4'h0) ? 1'b1 :            // [RULE12]
                    (ext_idx < EXT_CLKS) ? ext_rise[ext_idx[1:0]] : 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // time base: prescaled ticks step two low bits under the timer

    // shift amount kept three bits wide so ratio 1:64 does not fold back
    wire [7:0] pre_ratio = (8'h01 << {prescale_q[`PRESCALE_MSB:0], 1'b0}) - 8'h01;
    wire is_1to1   = prescale_q[`PRESCALE_MSB:0] == `PRESCALE_1TO1;
    // 1:1 bypasses the divider so every tick of the selected source counts [RULE7]
    wire base_tick = src_tick && (is_1to1 || pre_cnt_q == pre_ratio);
    wire last_q4   = (low_q == 2'h3) && (tmr_q == period_q);       // [RULE14]
    wire wrap      = base_tick && last_q4;
    wire [9:0] base_next = {tmr_q, low_q};                         // [RULE6]

    always @(posedge aclk) begin
        if (!aresetn) begin
            tmr_q          <= 8'h00;
            low_q          <= 2'h0;
            pre_cnt_q      <= 8'h00;
            duty_buf_q     <= 10'h000;
            width_bad_q    <= 1'b0;
            period_start_q <= 1'b0;
        end else begin
            period_start_q <= enable_q && wrap;
            if (!enable_q) begin
                tmr_q     <= 8'h00;
                low_q     <= 2'h0;
                pre_cnt_q <= 8'h00;
            end else if (src_tick) begin
                pre_cnt_q <= (is_1to1 || pre_cnt_q == pre_ratio) ? 8'h00 : pre_cnt_q + 8'h01;
                if (base_tick) begin
                    low_q <= low_q + 2'h1;
                    if (wrap) begin
                        tmr_q <= 8'h00;                              // [RULE1]
                    end else if (low_q == 2'h3) begin
                        tmr_q <= tmr_q + 8'h01;
                    end
                end
            end
            if (!enable_q || wrap) begin
                // latch the shadow pair for the next period [RULE3] [RULE5]
                duty_buf_q  <= {duty_hi_q, duty_lo_q[`DUTY_LO_MSB:`DUTY_LO_LSB]};
                // width above 4*(period+1) ticks cannot be produced [RULE10]
                // eleven bits: 4*(255+1) does not fit the time base width
                width_bad_q <= {1'b0, duty_hi_q, duty_lo_q[`DUTY_LO_MSB:`DUTY_LO_LSB]} >
                               ({1'b0, period_q, 2'h3} + 11'h001);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output: high for duty ticks of the time base [RULE8]

    always @(posedge aclk) begin
        if (!aresetn) begin
            pwm_out <= 1'b0;
        end else if (!enable_q) begin
            pwm_out <= 1'b0;
        end else if (width_bad_q) begin
            pwm_out <= pwm_out;                                      // [RULE11]
        end else if (base_next >= duty_buf_q) begin
            pwm_out <= 1'b0;                                 // [RULE13] [RULE2]
        end else begin
            pwm_out <= 1'b1;                                         // [RULE1]
        end
    end

endmodule

// File: dv/pwm_unit_asserts.sv
// concurrent checks on the bus and pwm pins of the timer pwm unit
// assumes it is bound into every instance of the top module
module pwm_unit_asserts (
    // clock and reset
    input logic        aclk,
    input logic        aresetn,
    // write channels
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic        s_axi_wvalid,
    input logic        s_axi_wready,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    // read channels
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic [31:0] s_axi_rdata,
    input logic [1:0]  s_axi_rresp,
    // pwm pin
    input logic        pwm_out
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////////////
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> s_axi_bvalid) else $error("write not answered");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_bresp_drops: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_read_cause: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
        else $error("read data without request");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data moved");
    a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    // reset must force quiet pins, so this one is not disabled by it
    a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid
        && !s_axi_rvalid && !pwm_out) else $error("pins busy after reset");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_pulse: cover property ($rose(pwm_out));
endmodule

bind timer_based_pwm_unit pwm_unit_asserts chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .pwm_out(pwm_out));

// File: dv/tb_timer_based_pwm_unit.sv
// self-checking bench of the timer pwm unit: bus master, pwm timing monitors
// assumes the register header is on the include path
`include "pwm_unit_regs.vh"
module tb_timer_based_pwm_unit;
    timeunit 1ns;
    timeprecision 1ns;
    logic        aclk, aresetn, awv, awr, wv, wr_r, bv, br, arv, arr, rv, rr, pwm_out;
    logic [11:0] awa, ara;
    logic [31:0] wd, rdat, r;
    logic [3:0]  ws, ext;
    logic [1:0]  bresp, rresp;
    logic [31:0] seed = 32'h0000003b;
    logic [34:0] rq[$];
    logic [1:0]  bq[$];
    int          error_cnt = 0;
    int          comparisons = 0;
    timer_based_pwm_unit DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
        .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .ext_clk_in(ext), .pwm_out(pwm_out));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic end_sim();
        $display("comparisons=%0d mismatches=%0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic tmo();
        error_cnt++;
        $display("wait ran out at %0t", $time);
        end_sim();
    endtask
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    // timer pins toggle at random; only a selected source may matter
    always @(posedge aclk) begin
        r = rnd();
        ext <= r[3:0];
    end
    // response monitor: oldest note against each answer
    always @(posedge aclk) begin
        logic [34:0] e;
        if (rv && rr) begin
            e = rq.pop_front();
            cmp(e[34] ? e[31:0] : rdat, e[31:0]);
            cmp(rresp, e[33:32]);
        end
        if (bv && br) cmp(bresp, bq.pop_front());
    end
    ////////////////////////////////////////////////////////////////////////////////
    // upper data bits are random junk; only bits 7:0 may land
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] e);
        logic ta, tw, tb;
        int n;
        @(posedge aclk);
        bq.push_back(e);
        awa <= a;
        wd <= {r[31:8], d};
        ws <= 4'hf;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        tb = 1'b0;
        for (n = 0; n < 64 && !tb; n++) begin
            @(negedge aclk);
            ta = awv && awr;
            tw = wv && wr_r;
            tb = bv;
            @(posedge aclk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
        end
        br <= 1'b0;
        if (!tb) tmo();
    endtask
    task automatic rd(input logic [11:0] a, input logic [34:0] e);
        logic ta, tr;
        int n;
        @(posedge aclk);
        rq.push_back(e);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        tr = 1'b0;
        for (n = 0; n < 64 && !tr; n++) begin
            @(negedge aclk);
            ta = arv && arr;
            tr = rv;
            @(posedge aclk);
            if (ta) arv <= 1'b0;
        end
        rr <= 1'b0;
        if (!tr) tmo();
    endtask
    // one full period from a rising edge: high cycles, then total length
    task automatic pw(input int hi, input int per);
        int n, h, t;
        for (n = 0; n < 4000 && pwm_out !== 1'b0; n++) @(negedge aclk);
        for (; n < 4000 && pwm_out !== 1'b1; n++) @(negedge aclk);
        h = 0;
        for (; n < 4000 && pwm_out === 1'b1; n++) begin
            @(negedge aclk);
            h++;
        end
        t = h;
        for (; n < 4000 && pwm_out === 1'b0; n++) begin
            @(negedge aclk);
            t++;
        end
        if (n >= 4000) tmo();
        cmp(h, hi);
        cmp(t, per);
    endtask
    // settle past the next period start, then count edges and high cycles
    task automatic watch(input int n, output int ch, output int hi);
        logic p;
        repeat (24) @(negedge aclk);
        p = pwm_out;
        ch = 0;
        hi = 0;
        repeat (n) begin
            @(negedge aclk);
            ch += (pwm_out !== p);
            hi += (pwm_out === 1'b1);
            p = pwm_out;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int ch, hi;
        {aresetn, awv, wv, br, arv, rr, awa, ara, wd, ws} = '0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`PERIOD_OFFSET, {3'h0, 32'h000000ff});
        rd(12'h100, {3'h2, 32'h0});
        wr(12'h100, 8'h5a, `RESP_SLVERR);
        $display("test registers done");
        wr(`CLKSEL_OFFSET, 8'h00, `RESP_OKAY);
        wr(`PERIOD_OFFSET, 8'h03, `RESP_OKAY);
        wr(`DUTY_HI_OFFSET, 8'h02, `RESP_OKAY);
        wr(`DUTY_LO_OFFSET, 8'h40, `RESP_OKAY);
        rd(`DUTY_LO_OFFSET, {3'h0, 32'h00000040});
        wr(`CONTROL_OFFSET, 8'h01, `RESP_OKAY);
        pw(9, 16);
        wr(`PRESCALE_OFFSET, 8'h3c, `RESP_OKAY);
        pw(9, 16);
        wr(`PRESCALE_OFFSET, 8'h01, `RESP_OKAY);
        pw(36, 64);
        wr(`PRESCALE_OFFSET, 8'h02, `RESP_OKAY);
        pw(144, 256);
        wr(`PRESCALE_OFFSET, 8'h03, `RESP_OKAY);
        pw(576, 1024);
        $display("test pulse width done");
        wr(`PRESCALE_OFFSET, 8'h00, `RESP_OKAY);
        wr(`DUTY_HI_OFFSET, 8'h00, `RESP_OKAY);
        wr(`DUTY_LO_OFFSET, 8'h00, `RESP_OKAY);
        watch(48, ch, hi);
        cmp(hi, 0);
        wr(`DUTY_HI_OFFSET, 8'hff, `RESP_OKAY);
        wr(`DUTY_LO_OFFSET, 8'hc0, `RESP_OKAY);
        watch(64, ch, hi);
        cmp(ch, 0);
        wr(`PERIOD_OFFSET, 8'hff, `RESP_OKAY);
        pw(1023, 1024);
        $display("test duty limits done");
        // short period again, then run the timer from the first pin
        wr(`CONTROL_OFFSET, 8'h00, `RESP_OKAY);
        wr(`PERIOD_OFFSET, 8'h03, `RESP_OKAY);
        wr(`DUTY_HI_OFFSET, 8'h02, `RESP_OKAY);
        wr(`DUTY_LO_OFFSET, 8'h40, `RESP_OKAY);
        wr(`CLKSEL_OFFSET, 8'h01, `RESP_OKAY);
        wr(`CONTROL_OFFSET, 8'h01, `RESP_OKAY);
        watch(160, ch, hi);
        cmp(ch != 0, 1);
        wr(`CLKSEL_OFFSET, 8'h0f, `RESP_OKAY);
        rd(`CLKSEL_OFFSET, {3'h0, 32'h0000000f});
        watch(64, ch, hi);
        cmp(ch, 0);
        $display("test clock source done");
        end_sim();
    end
endmodule
